// ===== shared/tasr_consts.vh
// Command codes, field values, status words and selection codes of the tag command decoder
`ifndef TASR_CONSTS_VH
`define TASR_CONSTS_VH

// Command header
`define TASR_CLA_ISO 8'h00
`define TASR_INS_SELECT 8'hA4
`define TASR_INS_READ 8'hB0
`define TASR_INS_WRITE 8'hD6
`define TASR_HDR_LEN 9'h005
`define TASR_IDX_CLA 9'h000
`define TASR_IDX_INS 9'h001
`define TASR_IDX_P1 9'h002
`define TASR_IDX_P2 9'h003
`define TASR_IDX_LEN 9'h004
`define TASR_CNT_MAX 9'h1FF

// Select parameter pairs and lengths
`define TASR_P1P2_EF 16'h020C
`define TASR_P1P2_APP 16'h0400
`define TASR_P1P2_FID 16'h000C
`define TASR_P2_NO_FCI 8'h0C
`define TASR_LC_APP 8'h07
`define TASR_LC_FID 8'h02
`define TASR_LE_APP 8'h00
`define TASR_FID_CC 16'hE103
`define TASR_FID_NDEF 16'h0103

// Read and write length ranges
`define TASR_RD_LE_MIN 8'h01
`define TASR_RD_LE_MAX 8'hFB
`define TASR_WR_LC_MIN 8'h01
`define TASR_WR_LC_MAX 8'hF8

// Status words
`define TASR_SW_OK 16'h9000
`define TASR_SW_CLA 16'h6E00
`define TASR_SW_INS 16'h6D00
`define TASR_SW_P1P2 16'h6A86
`define TASR_SW_LEN 16'h6700
`define TASR_SW_DATA 16'h6A82
`define TASR_SW_ADDR 16'h6B00

// Current selection
`define TASR_SEL_NONE 3'h0
`define TASR_SEL_APP 3'h1
`define TASR_SEL_CC 3'h2
`define TASR_SEL_NDEF 3'h3
`define TASR_SEL_EF 3'h4

// Actions after a passing check
`define TASR_ACT_NONE 2'h0
`define TASR_ACT_READ 2'h1
`define TASR_ACT_WRITE 2'h2

`endif

// ===== design/tasr_mem.v
// Byte-wide tag memory with one write port and a registered read port
`timescale 1ns/10ps
module tasr_mem #(
  parameter ADDR_W = 10
) (
  // Clock
  input wire clk,
  // Access
  input wire we,
  input wire [ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);

  reg [7:0] mem [0:(1 << ADDR_W)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// ===== design/tasr_apdu.v
// Tag command decoder: select, read and write with checks, own memory or host relay
// How it works
// - Any command with a non-zero class byte gets an error status.
// - Instruction A4 is select; first parameter picks file id, EF or name.
// - Only pairs 020C, 0400 and 000C are legal for select.
// - Select length byte must be 7 for application, 2 otherwise.
// - Application select accepts only the one seven-byte application id.
// - Pair 000C with id E103 selects the capability file.
// - Message file id is fixed 0103; pair 000C with it selects it.
// - Pair 020C accepts any two-byte file id.
// - Only application select data is checked; pair 000C with any other id selects an EF.
// - Response length byte 00 only on application select, else error.
// - Second parameter 0C means no control information, status only.
// - Every select is answered with exactly two status bytes.
// - Instruction B0 is read; both parameters form the start address.
// - Read length 1 to 251; that many bytes precede the status.
// - Read data is sent only with normal completion status.
// - Reads come from own memory in RF mode, from the host in tunnel.
// - Writes go to own memory in RF mode, to the host in tunnel.
`timescale 1ns/10ps
`include "tasr_consts.vh"
module tasr_apdu #(
  parameter ADDR_W = 10,
  parameter [55:0] APP_ID = 56'h0123456789ABCD // Arbitrary value
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RESET_N,
  // Command bytes from the link
  input wire CMD_VALID,
  input wire [7:0] CMD_DATA,
  input wire CMD_LAST,
  output wire CMD_READY,
  // Response bytes to the link
  output reg RSP_VALID,
  output reg [7:0] RSP_DATA,
  output reg RSP_LAST,
  input wire RSP_READY,
  // Mode pin
  input wire TUNNEL_MODE,
  // Host read relay
  output reg HOST_RD_REQ,
  output reg [15:0] HOST_RD_ADDR,
  output reg [7:0] HOST_RD_LEN,
  input wire HOST_RD_VALID,
  input wire [7:0] HOST_RD_DATA,
  output wire HOST_RD_READY,
  // Host write relay
  output wire HOST_WR_VALID,
  output reg [15:0] HOST_WR_ADDR,
  output reg [7:0] HOST_WR_DATA,
  input wire HOST_WR_READY,
  // Selection state
  output reg [2:0] SEL_STATE,
  output reg [15:0] EF_ID
);

  localparam [3:0] S_RX = 4'h0;
  localparam [3:0] S_CHECK = 4'h1;
  localparam [3:0] S_FETCH = 4'h2;
  localparam [3:0] S_LOAD = 4'h3;
  localparam [3:0] S_HDATA = 4'h4;
  localparam [3:0] S_WR = 4'h5;
  localparam [3:0] S_SW1 = 4'h6;
  localparam [3:0] S_SW2 = 4'h7;
  localparam [3:0] S_DONE = 4'h8;
  localparam [16:0] MEM_BYTES = 17'h00001 << ADDR_W;

  reg [3:0] state_q;
  reg [8:0] cnt_q;
  reg [7:0] cla_q, ins_q, p1_q, p2_q, len_q;
  reg [7:0] buf_mem [0:255];
  reg [15:0] sw_q;
  reg [15:0] ptr_q;
  reg [7:0] left_q;
  reg [7:0] idx_q;
  reg tun_q;
  reg mode_s1_q, mode_s2_q;
  wire rsp_fire;
  wire rsp_free;
  wire [7:0] mem_rdata;
  wire mem_we;
  wire [8:0] data_idx;

  // Command check results
  reg [15:0] sw_chk;
  reg [1:0] act_chk;
  reg sel_upd;
  reg [2:0] sel_new;
  reg [15:0] p1p2;
  reg [15:0] fid;
  reg [55:0] aid;
  reg [16:0] end_addr;

  assign rsp_fire = RSP_VALID && RSP_READY;
  assign rsp_free = !RSP_VALID || rsp_fire;
  assign CMD_READY = (state_q == S_RX);
  assign HOST_RD_READY = (state_q == S_HDATA) && rsp_free;
  assign HOST_WR_VALID = (state_q == S_WR) && tun_q;
  assign mem_we = (state_q == S_WR) && !tun_q;
  assign data_idx = cnt_q - `TASR_HDR_LEN;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode pin synchroniser
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      mode_s1_q <= TUNNEL_MODE;
      mode_s2_q <= mode_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Own memory
  tasr_mem #(
    .ADDR_W(ADDR_W)
  ) u_mem (
    .clk(REF_CLK),
    .we(mem_we),
    .addr(ptr_q[ADDR_W-1:0]),
    .wdata(buf_mem[idx_q]),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Command data buffer
  always @(posedge REF_CLK) begin
    if (CMD_VALID && CMD_READY && cnt_q >= `TASR_HDR_LEN && data_idx[8] == 1'b0) begin
      buf_mem[data_idx[7:0]] <= CMD_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command checks
  always @* begin
    p1p2 = {p1_q, p2_q};
    fid = {buf_mem[0], buf_mem[1]};
    aid = {buf_mem[0], buf_mem[1], buf_mem[2], buf_mem[3], buf_mem[4], buf_mem[5], buf_mem[6]};
    end_addr = {1'b0, p1p2} + {9'h000, len_q};
    sw_chk = `TASR_SW_OK;
    act_chk = `TASR_ACT_NONE;
    sel_upd = 1'b0;
    sel_new = SEL_STATE;
    if (cla_q != `TASR_CLA_ISO) begin
      sw_chk = `TASR_SW_CLA;
    end else begin
      case (ins_q)
        `TASR_INS_SELECT: begin
          if (p1p2 == `TASR_P1P2_APP) begin
            if (len_q != `TASR_LC_APP) begin
              sw_chk = `TASR_SW_LEN;
            end else if (cnt_q != `TASR_HDR_LEN + 9'h008 ||
                         buf_mem[7] != `TASR_LE_APP) begin
              sw_chk = `TASR_SW_LEN;
            end else if (aid != APP_ID) begin
              sw_chk = `TASR_SW_DATA;
            end else begin
              sel_upd = 1'b1;
              sel_new = `TASR_SEL_APP;
            end
          end else if (p1p2 == `TASR_P1P2_EF || p1p2 == `TASR_P1P2_FID) begin
            if (len_q != `TASR_LC_FID) begin
              sw_chk = `TASR_SW_LEN;
            end else if (cnt_q != `TASR_HDR_LEN + 9'h002) begin
              sw_chk = `TASR_SW_LEN;
            end else begin
              sel_upd = 1'b1;
              if (p1p2 == `TASR_P1P2_EF) begin
                sel_new = `TASR_SEL_EF;
              end else if (fid == `TASR_FID_CC) begin
                sel_new = `TASR_SEL_CC;
              end else if (fid == `TASR_FID_NDEF) begin
                sel_new = `TASR_SEL_NDEF;
              end else begin
                sel_new = `TASR_SEL_EF;
              end
            end
          end else begin
            sw_chk = `TASR_SW_P1P2;
          end
        end
        `TASR_INS_READ: begin
          if (cnt_q != `TASR_HDR_LEN || len_q < `TASR_RD_LE_MIN ||
              len_q > `TASR_RD_LE_MAX) begin
            sw_chk = `TASR_SW_LEN;
          end else if (!mode_s2_q && end_addr > MEM_BYTES) begin
            sw_chk = `TASR_SW_ADDR;
          end else begin
            act_chk = `TASR_ACT_READ;
          end
        end
        `TASR_INS_WRITE: begin
          if (len_q < `TASR_WR_LC_MIN || len_q > `TASR_WR_LC_MAX ||
              cnt_q != `TASR_HDR_LEN + {1'b0, len_q}) begin
            sw_chk = `TASR_SW_LEN;
          end else if (!mode_s2_q && end_addr > MEM_BYTES) begin
            sw_chk = `TASR_SW_ADDR;
          end else begin
            act_chk = `TASR_ACT_WRITE;
          end
        end
        default: begin
          sw_chk = `TASR_SW_INS;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= S_RX;
      cnt_q <= 9'h000;
      cla_q <= 8'h00;
      ins_q <= 8'h00;
      p1_q <= 8'h00;
      p2_q <= 8'h00;
      len_q <= 8'h00;
      sw_q <= 16'h0000;
      ptr_q <= 16'h0000;
      left_q <= 8'h00;
      idx_q <= 8'h00;
      tun_q <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
      RSP_LAST <= 1'b0;
      HOST_RD_REQ <= 1'b0;
      HOST_RD_ADDR <= 16'h0000;
      HOST_RD_LEN <= 8'h00;
      HOST_WR_ADDR <= 16'h0000;
      HOST_WR_DATA <= 8'h00;
      SEL_STATE <= `TASR_SEL_NONE;
      EF_ID <= 16'h0000;
    end else begin
      HOST_RD_REQ <= 1'b0;
      case (state_q)
        S_RX: begin
          if (CMD_VALID) begin
            case (cnt_q)
              `TASR_IDX_CLA: cla_q <= CMD_DATA;
              `TASR_IDX_INS: ins_q <= CMD_DATA;
              `TASR_IDX_P1: p1_q <= CMD_DATA;
              `TASR_IDX_P2: p2_q <= CMD_DATA;
              `TASR_IDX_LEN: len_q <= CMD_DATA;
              default: len_q <= len_q;
            endcase
            if (cnt_q != `TASR_CNT_MAX) begin
              cnt_q <= cnt_q + 9'h001;
            end
            if (CMD_LAST) begin
              state_q <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          // Selection, memory and host are not touched until every check has passed
          sw_q <= sw_chk;
          tun_q <= mode_s2_q;
          ptr_q <= p1p2;
          left_q <= len_q;
          idx_q <= 8'h00;
          if (sel_upd) begin
            SEL_STATE <= sel_new;
            EF_ID <= fid;
          end
          if (act_chk == `TASR_ACT_READ) begin
            if (mode_s2_q) begin
              HOST_RD_REQ <= 1'b1;
              HOST_RD_ADDR <= p1p2;
              HOST_RD_LEN <= len_q;
              state_q <= S_HDATA;
            end else begin
              state_q <= S_FETCH;
            end
          end else if (act_chk == `TASR_ACT_WRITE) begin
            HOST_WR_ADDR <= p1p2;
            HOST_WR_DATA <= buf_mem[0];
            state_q <= S_WR;
          end else begin
            state_q <= S_SW1;
          end
        end
        S_FETCH: begin
          // A data byte taken here must not be offered a second time
          if (rsp_fire) begin
            RSP_VALID <= 1'b0;
          end
          state_q <= S_LOAD;
        end
        S_LOAD: begin
          if (rsp_free) begin
            RSP_VALID <= 1'b1;
            RSP_DATA <= mem_rdata;
            RSP_LAST <= 1'b0;
            ptr_q <= ptr_q + 16'h0001;
            left_q <= left_q - 8'h01;
            state_q <= (left_q == 8'h01) ? S_SW1 : S_FETCH;
          end
        end
        S_HDATA: begin
          if (rsp_fire) begin
            RSP_VALID <= 1'b0;
          end
          if (HOST_RD_VALID && HOST_RD_READY) begin
            RSP_VALID <= 1'b1;
            RSP_DATA <= HOST_RD_DATA;
            RSP_LAST <= 1'b0;
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01) begin
              state_q <= S_SW1;
            end
          end
        end
        S_WR: begin
          if (!tun_q || HOST_WR_READY) begin
            ptr_q <= ptr_q + 16'h0001;
            idx_q <= idx_q + 8'h01;
            left_q <= left_q - 8'h01;
            HOST_WR_ADDR <= ptr_q + 16'h0001;
            HOST_WR_DATA <= buf_mem[idx_q + 8'h01];
            if (left_q == 8'h01) begin
              state_q <= S_SW1;
            end
          end
        end
        S_SW1: begin
          if (rsp_free) begin
            RSP_VALID <= 1'b1;
            RSP_DATA <= sw_q[15:8];
            RSP_LAST <= 1'b0;
            state_q <= S_SW2;
          end
        end
        S_SW2: begin
          if (rsp_fire) begin
            RSP_DATA <= sw_q[7:0];
            RSP_LAST <= 1'b1;
            state_q <= S_DONE;
          end
        end
        S_DONE: begin
          if (rsp_fire) begin
            RSP_VALID <= 1'b0;
            RSP_LAST <= 1'b0;
            cnt_q <= 9'h000;
            state_q <= S_RX;
          end
        end
        default: begin
          state_q <= S_RX;
        end
      endcase
    end
  end

endmodule

// ===== bench/tasr_apdu_chk.sv
// Port checker for the tag command decoder
`timescale 1ns/10ps
module tasr_apdu_chk (
  // Clock and reset
  input wire REF_CLK,
  input wire RESET_N,
  // Watched ports
  input wire CMD_READY,
  input wire RSP_VALID,
  input wire [7:0] RSP_DATA,
  input wire RSP_LAST,
  input wire RSP_READY,
  input wire HOST_RD_REQ,
  input wire [7:0] HOST_RD_LEN,
  input wire HOST_RD_READY,
  input wire HOST_WR_VALID,
  input wire [2:0] SEL_STATE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////
  chk_rsp_hold: assert property (
    RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_DATA) && $stable(RSP_LAST))
    else $error("response byte changed before taken");
  chk_last_end: assert property (
    RSP_VALID && RSP_READY && RSP_LAST |=> !RSP_VALID && CMD_READY)
    else $error("response did not end after second status byte");
  chk_busy_refuse: assert property (
    RSP_VALID |-> !CMD_READY)
    else $error("command taken while answering");
  chk_sel_quiet: assert property (
    $changed(SEL_STATE) |-> !CMD_READY)
    else $error("selection changed outside a command");
  chk_req_pulse: assert property (
    HOST_RD_REQ |=> !HOST_RD_REQ)
    else $error("host read request longer than one cycle");
  chk_req_len: assert property (
    HOST_RD_REQ |-> HOST_RD_LEN >= 8'h01 && HOST_RD_LEN <= 8'hFB)
    else $error("host read length out of range");
  chk_wr_quiet: assert property (
    HOST_WR_VALID |-> !CMD_READY && !RSP_VALID)
    else $error("host write outside a checked command");
  chk_rd_quiet: assert property (
    HOST_RD_READY |-> !CMD_READY)
    else $error("host read taken while idle");
  cover property (RSP_VALID && RSP_READY && RSP_LAST);
  cover property (HOST_RD_REQ);
  cover property (HOST_WR_VALID);
endmodule

// ===== bench/tasr_host.sv
// Host-side model answering tunnel reads and writes
`timescale 1ns/10ps
module tasr_host (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // High makes the host answer every other cycle
  input wire slow,
  // Read relay
  input wire rd_req,
  input wire [15:0] rd_addr,
  input wire [7:0] rd_len,
  output reg rd_valid,
  output reg [7:0] rd_data,
  input wire rd_ready,
  // Write relay
  input wire wr_valid,
  input wire [15:0] wr_addr,
  input wire [7:0] wr_data,
  output reg wr_ready
);
  reg [15:0] a_q;
  reg [8:0] n_q;
  reg t_q;
  integer wr_cnt;
  reg [7:0] mem [0:1023];
  ////////////////////////////////
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      n_q <= 9'h000;
      t_q <= 1'b0;
      wr_ready <= 1'b0;
      wr_cnt <= 0;
    end else begin
      t_q <= ~t_q;
      wr_ready <= ~slow | t_q;
      if (wr_valid && wr_ready) begin
        mem[wr_addr[9:0]] <= wr_data;
        wr_cnt <= wr_cnt + 1;
      end
      if (rd_req) begin
        a_q <= rd_addr;
        n_q <= {1'b0, rd_len};
      end else if (rd_valid && rd_ready) begin
        // Released line no longer shows the old byte
        rd_valid <= 1'b0;
        rd_data <= ~rd_data;
        a_q <= a_q + 16'h0001;
        n_q <= n_q - 9'h001;
      end else if (n_q != 9'h000 && (~slow | t_q)) begin
        rd_valid <= 1'b1;
        rd_data <= a_q[7:0] ^ a_q[15:8] ^ 8'h3C;
      end
    end
  end
endmodule

// ===== bench/tag_apdu_select_read_test.sv
// Self-checking bench of the tag command decoder
`timescale 1ns/10ps
`include "tasr_consts.vh"
module tag_apdu_select_read_test;
  localparam [55:0] AID = 56'h1122334455AA77; // Arbitrary value
  reg REF_CLK, RESET_N, CMD_VALID, CMD_LAST, RSP_READY, TUNNEL_MODE, slow;
  reg [7:0] CMD_DATA;
  wire CMD_READY, RSP_VALID, RSP_LAST, HOST_RD_REQ, HOST_RD_VALID, HOST_RD_READY;
  wire HOST_WR_VALID, HOST_WR_READY;
  wire [7:0] RSP_DATA, HOST_RD_LEN, HOST_RD_DATA, HOST_WR_DATA;
  wire [15:0] HOST_RD_ADDR, HOST_WR_ADDR, EF_ID;
  wire [2:0] SEL_STATE;
  integer seed = 76, failures = 0, checked = 0, i, n0;
  reg [7:0] cq [$], eq [$], got [$], mm [0:1023];
  reg [15:0] a, x;
  reg [7:0] b;
  ////////////////////////////////
  tasr_apdu #(.APP_ID(AID)) dut_u (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .CMD_VALID(CMD_VALID), .CMD_DATA(CMD_DATA), .CMD_LAST(CMD_LAST), .CMD_READY(CMD_READY),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RSP_LAST(RSP_LAST), .RSP_READY(RSP_READY),
    .TUNNEL_MODE(TUNNEL_MODE), .HOST_RD_REQ(HOST_RD_REQ), .HOST_RD_ADDR(HOST_RD_ADDR),
    .HOST_RD_LEN(HOST_RD_LEN), .HOST_RD_VALID(HOST_RD_VALID), .HOST_RD_DATA(HOST_RD_DATA),
    .HOST_RD_READY(HOST_RD_READY), .HOST_WR_VALID(HOST_WR_VALID),
    .HOST_WR_ADDR(HOST_WR_ADDR), .HOST_WR_DATA(HOST_WR_DATA),
    .HOST_WR_READY(HOST_WR_READY), .SEL_STATE(SEL_STATE), .EF_ID(EF_ID));
  tasr_host host_u (.clk(REF_CLK), .rst_n(RESET_N), .slow(slow), .rd_req(HOST_RD_REQ),
    .rd_addr(HOST_RD_ADDR), .rd_len(HOST_RD_LEN), .rd_valid(HOST_RD_VALID),
    .rd_data(HOST_RD_DATA), .rd_ready(HOST_RD_READY), .wr_valid(HOST_WR_VALID),
    .wr_addr(HOST_WR_ADDR), .wr_data(HOST_WR_DATA), .wr_ready(HOST_WR_READY));
  ////////////////////////////////
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  task end_sim;
    begin
      if (failures == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task hdr(input [7:0] c, input [7:0] ins, input [15:0] p, input [7:0] l);
    begin
      cq = {c, ins, p[15:8], p[7:0], l};
      eq = {};
    end
  endtask
  // Sends cq, collects the answer under random stalls, compares with eq and status
  task run(input [15:0] sw, input [2:0] s);
    integer k, t;
    reg done;
    begin
      for (k = 0; k < cq.size(); k = k + 1) begin
        @(negedge REF_CLK);
        CMD_VALID = 1'b1;
        CMD_DATA = cq[k];
        CMD_LAST = (k == cq.size() - 1);
        while (!CMD_READY)
          @(negedge REF_CLK);
        @(posedge REF_CLK);
      end
      @(negedge REF_CLK);
      CMD_VALID = 1'b0;
      CMD_LAST = 1'b0;
      CMD_DATA = ~CMD_DATA;
      got = {};
      done = 1'b0;
      for (t = 0; t < 4000 && !done; t = t + 1) begin
        RSP_READY = $random(seed);
        if (RSP_VALID && RSP_READY) begin
          got.push_back(RSP_DATA);
          done = RSP_LAST;
        end
        @(negedge REF_CLK);
      end
      eq.push_back(sw[15:8]);
      eq.push_back(sw[7:0]);
      chk(got.size(), eq.size());
      for (k = 0; k < eq.size() && k < got.size(); k = k + 1)
        chk(got[k], eq[k]);
      chk(SEL_STATE, s);
    end
  endtask
  task fsel(input [7:0] c, input [15:0] p, input [7:0] l, input [15:0] id, input [15:0] sw,
    input [2:0] s);
    begin
      hdr(c, `TASR_INS_SELECT, p, l);
      cq = {cq, id[15:8], id[7:0]};
      run(sw, s);
    end
  endtask
  task app(input [55:0] id, input [7:0] le, input [15:0] sw);
    begin
      hdr(8'h00, `TASR_INS_SELECT, 16'h0400, 8'h07);
      for (i = 6; i >= 0; i = i - 1)
        cq.push_back(id[i*8+:8]);
      cq.push_back(le);
      run(sw, 3'h1);
    end
  endtask
  // Own-memory write followed by a read back of the same span
  task rw(input [15:0] ad, input [7:0] n);
    begin
      hdr(8'h00, `TASR_INS_WRITE, ad, n);
      for (i = 0; i < n; i = i + 1) begin
        b = $random(seed);
        cq.push_back(b);
        mm[ad[9:0] + i] = b;
      end
      run(`TASR_SW_OK, 3'h1);
      hdr(8'h00, `TASR_INS_READ, ad, n);
      for (i = 0; i < n; i = i + 1)
        eq.push_back(mm[ad[9:0] + i]);
      run(`TASR_SW_OK, 3'h1);
    end
  endtask
  initial begin
    {RESET_N, CMD_VALID, CMD_LAST, RSP_READY, TUNNEL_MODE, slow} = 6'h00;
    CMD_DATA = 8'h00;
    repeat (5) @(negedge REF_CLK);
    RESET_N = 1'b1;
    fsel(8'h01, 16'h000C, 8'h02, 16'hE103, `TASR_SW_CLA, 3'h0);
    fsel(8'h00, 16'h000C, 8'h02, 16'hE103, `TASR_SW_OK, 3'h2);
    fsel(8'h00, 16'h000C, 8'h02, 16'h0103, `TASR_SW_OK, 3'h3);
    fsel(8'h00, 16'h0104, 8'h02, 16'h0103, `TASR_SW_P1P2, 3'h3);
    fsel(8'h00, 16'h000C, 8'h03, 16'h0103, `TASR_SW_LEN, 3'h3);
    a = $random(seed);
    fsel(8'h00, 16'h020C, 8'h02, a, `TASR_SW_OK, 3'h4);
    chk(EF_ID, a);
    fsel(8'h00, 16'h000C, 8'h02, 16'h1234, `TASR_SW_OK, 3'h4);
    chk(EF_ID, 16'h1234);
    app(AID, 8'h00, `TASR_SW_OK);
    app(AID ^ 56'h1, 8'h00, `TASR_SW_DATA);
    app(AID, 8'h01, `TASR_SW_LEN);
    hdr(8'h00, `TASR_INS_SELECT, 16'h000C, 8'h02);
    cq = {cq, 8'hE1, 8'h03, 8'h00};
    run(`TASR_SW_LEN, 3'h1);
    hdr(8'h01, `TASR_INS_READ, 16'h0000, 8'h04);
    run(`TASR_SW_CLA, 3'h1);
    hdr(8'h00, 8'hCA, 16'h0000, 8'h00);
    run(`TASR_SW_INS, 3'h1);
    b = $random(seed);
    rw({8'h02, b}, 8'h10);
    rw(16'h03FF, 8'h01);
    // A refused write must leave the stored byte untouched
    hdr(8'h00, `TASR_INS_WRITE, 16'h03FF, 8'h02);
    cq.push_back(~mm[10'h3FF]);
    run(`TASR_SW_LEN, 3'h1);
    hdr(8'h00, `TASR_INS_READ, 16'h03FF, 8'h01);
    eq.push_back(mm[10'h3FF]);
    run(`TASR_SW_OK, 3'h1);
    hdr(8'h00, `TASR_INS_READ, 16'h0200, 8'h00);
    run(`TASR_SW_LEN, 3'h1);
    hdr(8'h00, `TASR_INS_READ, 16'h0200, 8'hFC);
    run(`TASR_SW_LEN, 3'h1);
    hdr(8'h00, `TASR_INS_READ, 16'h03FF, 8'h02);
    run(`TASR_SW_ADDR, 3'h1);
    TUNNEL_MODE = 1'b1;
    slow = 1'b1;
    repeat (3) @(negedge REF_CLK);
    a = $random(seed);
    hdr(8'h00, `TASR_INS_READ, a, 8'hFB);
    for (i = 0; i < 251; i = i + 1) begin
      x = a + i;
      eq.push_back(x[7:0] ^ x[15:8] ^ 8'h3C);
    end
    run(`TASR_SW_OK, 3'h1);
    a = $random(seed);
    hdr(8'h00, `TASR_INS_WRITE, a, 8'h08);
    for (i = 0; i < 8; i = i + 1)
      cq.push_back($random(seed));
    n0 = host_u.wr_cnt;
    run(`TASR_SW_OK, 3'h1);
    chk(host_u.wr_cnt - n0, 8);
    for (i = 0; i < 8; i = i + 1) begin
      x = a + i;
      chk(host_u.mem[x[9:0]], cq[5+i]);
    end
    end_sim;
  end
  initial begin
    // About thirty times the expected run, well under the cycle budget
    #400000;
    failures = failures + 1;
    end_sim;
  end
endmodule
bind tasr_apdu tasr_apdu_chk chk_u (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RSP_LAST(RSP_LAST),
  .RSP_READY(RSP_READY), .HOST_RD_REQ(HOST_RD_REQ), .HOST_RD_LEN(HOST_RD_LEN),
  .HOST_RD_READY(HOST_RD_READY), .HOST_WR_VALID(HOST_WR_VALID), .SEL_STATE(SEL_STATE));
